// ===== rtl/rtcoc_pkg.sv
// Shared constants for the slow timebase oscillator control block.
// Assumes a 100 MHz system clock and byte-wide indirect register access.
`default_nettype none

package rtcoc_pkg;

	// Indirect register addresses
	localparam logic [7:0] ADDR_CAP_BASE = 8'h00; // Six snapshot bytes, 0x00..0x05
	localparam logic [7:0] ADDR_CTRL = 8'h06; // rtc_control
	localparam logic [7:0] ADDR_OSC = 8'h07; // osc_control_register
	localparam logic [7:0] ADDR_ALARM_BASE = 8'h08; // Six alarm bytes, 0x08..0x0d
	localparam int unsigned NBYTES = 6; // Bytes in each snapshot/alarm group
	localparam logic [7:0] NBYTES_B = 8'h06; // Same count at address width

	// rtc_control field positions
	localparam int unsigned CTRL_EN = 7; // osc_power_enable
	localparam int unsigned CTRL_MCLK = 6; // lost_clock_detect_enable
	localparam int unsigned CTRL_FAIL = 5; // clock_fail_flag
	localparam int unsigned CTRL_RUN = 4; // timer_run
	localparam int unsigned CTRL_AEN = 3; // alarm_event_enable
	localparam int unsigned CTRL_ALARM_FLAG = 2; // alarm_flag
	localparam int unsigned CTRL_LOAD = 1; // timer_load_bit
	localparam int unsigned CTRL_SNAP = 0; // timer_snapshot_bit

	// osc_control_register field positions
	localparam int unsigned OSC_AGC = 7; // gain_control_enable
	localparam int unsigned OSC_MODE = 6; // osc_mode_select, 1 = crystal
	localparam int unsigned OSC_BIAS = 5; // bias_double
	localparam int unsigned OSC_VLD = 4; // clock_valid, read only

	// Reset values
	localparam logic [7:0] CAP_RESET = 8'hff; // Snapshot bytes
	localparam logic [7:0] ALARM_RESET = 8'hff; // Alarm bytes
	localparam logic MODE_SELF_OSC = 1'b0; // Self-oscillate after reset

	// Timer geometry
	localparam int unsigned TIMER_W = 47; // Timebase counter width

	// Missing clock detection window
	localparam int unsigned SYS_CLK_PERIOD_NS = 10; // 100 MHz
	localparam int unsigned MISS_TIME_NS = 50000; // 50 us stuck level
	localparam int unsigned MISS_CNT_W = 16; // Counter width
	localparam logic [MISS_CNT_W-1:0] MISS_CYCLES_DEF =
		MISS_CNT_W'(MISS_TIME_NS / SYS_CLK_PERIOD_NS);

endpackage

`default_nettype wire

// ===== rtl/rtcoc_sync.sv
// Two flip-flop synchroniser for levels arriving from outside sys_clk.
// Assumes the inputs are slow compared to sys_clk.
`default_nettype none

module rtcoc_sync #(
	parameter int unsigned W = 1
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [W-1:0] asyncIn,
	output logic [W-1:0] syncOut
);

	logic [W-1:0] meta_r; // First stage, read only by the second

	// Both stages clear to zero under synchronous reset
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			meta_r <= '0;
			syncOut <= '0;
		end
		else
		begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end

endmodule

`default_nettype wire

// ===== rtl/rtcoc_top.sv
// Slow timebase oscillator control, control register, timer and lost clock detector.
// Assumes the analog oscillator delivers its clock and a valid level as pins,
// and that the core reaches registers through the address/data port pair.
`default_nettype none

// What this block does
// R1: Timebase runs from its own slow clock
// R2: Mode bit one crystal, zero self-oscillate
// R3: Software starts crystal then polls clock valid
// R4: Self-oscillate frequency chosen by bias double
// R5: Self-oscillate clock runs with no wait
// R6: Bit seven enables automatic gain control
// R7: Software avoids gain control in self-oscillate
// R8: Bit five doubles oscillator bias current
// R9: Crystal bias double gives robustness, costs power
// R10: Detector flags clock stuck beyond 50 us
// R11: Fail wakes oscillator, interrupts, resets part
// R12: Software disables detector before oscillator changes
// R13: Slow clock routable as system clock, pin
// R14: Slow clock edges measurable by general timer
// R15: Running timer counts every slow clock cycle
// R16: Load bit copies snapshot into timer, self-clears
// R17: Snapshot bit copies timer, LSB at bit1
// R18: Alarm when timer reaches alarm value, enabled
// R19: Alarm and fail flags clear only by software
// R20: Registers reached through address and data ports
module rtcoc_top #(
	parameter logic [rtcoc_pkg::MISS_CNT_W-1:0] MISS_CYCLES = rtcoc_pkg::MISS_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic slowClkPin,
	input wire logic clockValidPin,
	input wire logic addrWrEn,
	input wire logic [7:0] addrIn,
	input wire logic dataWrEn,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	input wire logic rtcIrqEnable,
	input wire logic rtcResetSrcEnable,
	output logic oscPowerEnable,
	output logic oscModeSelect,
	output logic gainControlEnable,
	output logic biasDouble,
	output logic slowClkRouted,
	output logic timerCaptureTick,
	output logic rtcIrq,
	output logic mcuResetReq,
	output logic wakeInternalOsc
);

	localparam int unsigned TW = rtcoc_pkg::TIMER_W;
	localparam int unsigned NB = rtcoc_pkg::NBYTES;

	// Joins a byte group into one word, byte 0 lowest
	function automatic logic [8*NB-1:0] packBytes(input logic [7:0] b [NB]);
		logic [8*NB-1:0] w;
		w = '0;
		for (int i = 0; i < NB; i++)
			w[8*i +: 8] = b[i];
		return w;
	endfunction

	// Synchronised pins: slow clock level and clock-valid level
	logic slowSync; // Slow clock after two flops
	logic vldSync; // Clock valid after two flops
	rtcoc_sync #(.W(2)) uSync (
		.sys_clk(sys_clk),
		.srst(srst),
		.asyncIn({slowClkPin, clockValidPin}),
		.syncOut({slowSync, vldSync})
	);

	// State
	logic [7:0] addr_r, addr_nxt; // Indirect address
	logic en_r, en_nxt, mclk_r, mclk_nxt, fail_r, fail_nxt; // Control bits
	logic run_r, run_nxt, aen_r, aen_nxt, alarm_flag_r, alarm_flag_nxt;
	logic load_r, load_nxt, snap_r, snap_nxt;
	logic agc_r, agc_nxt, mode_r, mode_nxt, bias_r, bias_nxt; // Oscillator bits
	logic [TW-1:0] timer_r, timer_nxt; // Timebase counter
	logic [7:0] cap_r [NB]; // Snapshot bytes
	logic [7:0] cap_nxt [NB];
	logic [7:0] alarm_r [NB]; // Alarm bytes
	logic [7:0] alarm_nxt [NB];
	logic [rtcoc_pkg::MISS_CNT_W-1:0] miss_r, miss_nxt; // Cycles since last slow edge
	logic slowPrev_r; // Slow clock one cycle back, for edges
	logic [7:0] rd_nxt; // Read mux
	logic failEvt, alarmHit, alarmSet, slowRise, slowEdge;
	logic wrCtrl, wrOsc;
	logic [8*NB-1:0] capVal, alarmVal;

	assign capVal = packBytes(cap_r);
	assign alarmVal = packBytes(alarm_r);
	assign slowRise = slowSync & ~slowPrev_r;
	assign slowEdge = slowSync ^ slowPrev_r;
	assign wrCtrl = dataWrEn && (addr_r == rtcoc_pkg::ADDR_CTRL); // R20
	assign wrOsc = dataWrEn && (addr_r == rtcoc_pkg::ADDR_OSC); // R20
	// Compare against the timer bits only; byte 0 bit 0 is unused
	assign alarmHit = aen_r && (timer_r >= alarmVal[TW:1]); // R18
	assign alarmSet = alarmHit && !alarm_flag_r;

	// Next-state logic for registers, timer and detector
	always_comb
	begin
		addr_nxt = addrWrEn ? addrIn : addr_r; // R20
		en_nxt = en_r;
		mclk_nxt = mclk_r;
		run_nxt = run_r;
		aen_nxt = aen_r;
		agc_nxt = agc_r;
		mode_nxt = mode_r;
		bias_nxt = bias_r;
		cap_nxt = cap_r;
		alarm_nxt = alarm_r;
		timer_nxt = timer_r;
		failEvt = 1'b0;
		// Transfers last one cycle, then the bits drop by themselves
		load_nxt = 1'b0; // R16
		snap_nxt = 1'b0; // R17
		if (wrCtrl)
		begin
			en_nxt = dataIn[rtcoc_pkg::CTRL_EN];
			mclk_nxt = dataIn[rtcoc_pkg::CTRL_MCLK];
			run_nxt = dataIn[rtcoc_pkg::CTRL_RUN];
			aen_nxt = dataIn[rtcoc_pkg::CTRL_AEN];
			load_nxt = dataIn[rtcoc_pkg::CTRL_LOAD] & ~load_r;
			snap_nxt = dataIn[rtcoc_pkg::CTRL_SNAP] & ~snap_r;
		end
		// Oscillator settings; no bias or gain lock-outs in any mode
		if (wrOsc)
		begin
			agc_nxt = dataIn[rtcoc_pkg::OSC_AGC]; // R6
			mode_nxt = dataIn[rtcoc_pkg::OSC_MODE]; // R2
			bias_nxt = dataIn[rtcoc_pkg::OSC_BIAS]; // R8
		end
		// Byte groups written by software, out-of-range addresses ignored
		if (dataWrEn && addr_r < rtcoc_pkg::ADDR_CAP_BASE + rtcoc_pkg::NBYTES_B)
			cap_nxt[addr_r[2:0]] = dataIn;
		if (dataWrEn && addr_r >= rtcoc_pkg::ADDR_ALARM_BASE
			&& addr_r < rtcoc_pkg::ADDR_ALARM_BASE + rtcoc_pkg::NBYTES_B)
			alarm_nxt[3'(addr_r - rtcoc_pkg::ADDR_ALARM_BASE)] = dataIn;
		// Timer: load beats counting in the same cycle
		if (load_r)
			timer_nxt = capVal[TW:1]; // R16
		else if (run_r && slowRise)
			timer_nxt = timer_r + TW'(1); // R15
		// Snapshot wins over a software byte write in the same cycle
		if (snap_r)
		begin
			for (int i = 0; i < NB; i++)
				cap_nxt[i] = 8'({timer_r, 1'b0} >> (8 * i)); // R17
		end
		// Missing clock one-shot: counts while the level holds, fires once
		if (slowEdge || !mclk_r)
			miss_nxt = '0;
		else if (miss_r != MISS_CYCLES)
		begin
			miss_nxt = miss_r + 16'h1;
			failEvt = (miss_r == MISS_CYCLES - 16'h1); // R10
		end
		else
			miss_nxt = miss_r;
		// Sticky flags: software writes zero to clear, set wins
		fail_nxt = (fail_r && !(wrCtrl && !dataIn[rtcoc_pkg::CTRL_FAIL])) || failEvt; // R19
		alarm_flag_nxt = (alarm_flag_r && !(wrCtrl && !dataIn[rtcoc_pkg::CTRL_ALARM_FLAG])) || alarmHit; // R19
		// Read mux on the current address
		if (addr_r < rtcoc_pkg::ADDR_CAP_BASE + rtcoc_pkg::NBYTES_B)
			rd_nxt = cap_r[addr_r[2:0]];
		else if (addr_r == rtcoc_pkg::ADDR_CTRL)
			rd_nxt = {en_r, mclk_r, fail_r, run_r, aen_r, alarm_flag_r, load_r, snap_r};
		else if (addr_r == rtcoc_pkg::ADDR_OSC)
			rd_nxt = {agc_r, mode_r, bias_r, vldSync, 4'h0}; // R3
		else if (addr_r >= rtcoc_pkg::ADDR_ALARM_BASE
			&& addr_r < rtcoc_pkg::ADDR_ALARM_BASE + rtcoc_pkg::NBYTES_B)
			rd_nxt = alarm_r[3'(addr_r - rtcoc_pkg::ADDR_ALARM_BASE)];
		else
			rd_nxt = 8'h00; // Unmapped reads zero
	end

	// Register stage; all outputs come from here
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			addr_r <= 8'h00;
			{en_r, mclk_r, fail_r, run_r} <= 4'h0;
			{aen_r, alarm_flag_r, load_r, snap_r} <= 4'h0;
			agc_r <= 1'b0;
			mode_r <= rtcoc_pkg::MODE_SELF_OSC;
			bias_r <= 1'b0;
			timer_r <= '0;
			for (int i = 0; i < NB; i++)
			begin
				cap_r[i] <= rtcoc_pkg::CAP_RESET;
				alarm_r[i] <= rtcoc_pkg::ALARM_RESET;
			end
			miss_r <= '0;
			slowPrev_r <= 1'b0;
			dataOut <= 8'h00;
			{oscPowerEnable, oscModeSelect, gainControlEnable, biasDouble} <= 4'h0;
			{slowClkRouted, timerCaptureTick, rtcIrq, mcuResetReq} <= 4'h0;
			wakeInternalOsc <= 1'b0;
		end
		else
		begin
			addr_r <= addr_nxt;
			{en_r, mclk_r, fail_r, run_r} <= {en_nxt, mclk_nxt, fail_nxt, run_nxt};
			{aen_r, alarm_flag_r, load_r, snap_r} <= {aen_nxt, alarm_flag_nxt, load_nxt, snap_nxt};
			agc_r <= agc_nxt;
			mode_r <= mode_nxt;
			bias_r <= bias_nxt;
			timer_r <= timer_nxt;
			cap_r <= cap_nxt;
			alarm_r <= alarm_nxt;
			miss_r <= miss_nxt;
			slowPrev_r <= slowSync;
			dataOut <= rd_nxt;
			// Oscillator steering: in self-oscillate bias picks 20 or 40 kHz
			oscPowerEnable <= en_nxt; // R1
			oscModeSelect <= mode_nxt; // R2 R5
			gainControlEnable <= agc_nxt; // R6
			biasDouble <= bias_nxt; // R4 R8 R9
			slowClkRouted <= slowSync; // R13
			timerCaptureTick <= slowRise; // R14
			rtcIrq <= rtcIrqEnable && (fail_nxt || alarm_flag_nxt); // R11
			mcuResetReq <= rtcResetSrcEnable && (fail_nxt || alarm_flag_nxt); // R11
			wakeInternalOsc <= failEvt || alarmSet; // R11
		end
	end

	property p_load_clear;
		@(posedge sys_clk) disable iff (srst) load_r |=> !load_r;
	endproperty
	a_load_clear: assert property (p_load_clear) else $error("load bit stayed set"); // R16

	property p_load_copy;
		@(posedge sys_clk) disable iff (srst) load_r |=> timer_r == $past(capVal[TW:1]);
	endproperty
	a_load_copy: assert property (p_load_copy) else $error("timer not loaded"); // R16

	property p_snap_copy;
		@(posedge sys_clk) disable iff (srst) snap_r |=> capVal == {$past(timer_r), 1'b0};
	endproperty
	a_snap_copy: assert property (p_snap_copy) else $error("snapshot wrong"); // R17

	property p_run_inc;
		@(posedge sys_clk) disable iff (srst)
			run_r && slowRise && !load_r |=> timer_r == $past(timer_r) + TW'(1);
	endproperty
	a_run_inc: assert property (p_run_inc) else $error("timer missed a tick"); // R15

	property p_alarm_set;
		@(posedge sys_clk) disable iff (srst) alarmHit |=> alarm_flag_r && rtcIrq == $past(rtcIrqEnable);
	endproperty
	a_alarm_set: assert property (p_alarm_set) else $error("alarm not flagged"); // R18

	property p_fail_sticky;
		@(posedge sys_clk) disable iff (srst) fail_r && !wrCtrl |=> fail_r;
	endproperty
	a_fail_sticky: assert property (p_fail_sticky) else $error("fail flag lost"); // R19

	property p_alarm_sticky;
		@(posedge sys_clk) disable iff (srst) alarm_flag_r && !wrCtrl |=> alarm_flag_r;
	endproperty
	a_alarm_sticky: assert property (p_alarm_sticky) else $error("alarm flag lost"); // R19

	property p_fail_time;
		@(posedge sys_clk) disable iff (srst)
			mclk_r && !slowEdge && miss_r == MISS_CYCLES - 16'h1 |=> fail_r ##0 wakeInternalOsc;
	endproperty
	a_fail_time: assert property (p_fail_time) else $error("missing clock not caught"); // R10 R11

	property p_osc_write;
		@(posedge sys_clk) disable iff (srst)
			wrOsc |=> oscModeSelect == $past(dataIn[rtcoc_pkg::OSC_MODE])
				&& biasDouble == $past(dataIn[rtcoc_pkg::OSC_BIAS]);
	endproperty
	a_osc_write: assert property (p_osc_write) else $error("oscillator bits not applied"); // R2 R8

endmodule

`default_nettype wire

// ===== tb/rtcoc_top_tb.sv
// Bench for the slow timebase oscillator control block.
// Assumes rtcoc_pkg is compiled first; bench drives every port itself.
`default_nettype none

module rtcoc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'b0; // 100 MHz clock
	logic srst = 1'b1; // Held for five cycles
	logic slowClkPin = 1'b0; // Still until a test toggles it
	logic clockValidPin = 1'b0; // Oscillator not yet stable
	logic addrWrEn = 1'b0;
	logic [7:0] addrIn = 8'h00;
	logic dataWrEn = 1'b0;
	logic [7:0] dataIn = 8'h00;
	logic [7:0] dataOut;
	logic rtcIrqEnable = 1'b1; // Interrupt path enabled
	logic rtcResetSrcEnable = 1'b1; // Reset path enabled
	logic oscPowerEnable, oscModeSelect, gainControlEnable, biasDouble;
	logic slowClkRouted, timerCaptureTick, rtcIrq, mcuResetReq, wakeInternalOsc;
	int nErrors = 0;
	int nCompared = 0;
	int ticks = 0; // Slow edge pulses seen
	int wakes = 0; // Wake pulses seen
	logic [7:0] rd;

	// Short detector window keeps the run brief
	rtcoc_top #(.MISS_CYCLES(16'h0014)) dut (.sys_clk(sys_clk), .srst(srst),
		.slowClkPin(slowClkPin), .clockValidPin(clockValidPin), .addrWrEn(addrWrEn),
		.addrIn(addrIn), .dataWrEn(dataWrEn), .dataIn(dataIn), .dataOut(dataOut),
		.rtcIrqEnable(rtcIrqEnable), .rtcResetSrcEnable(rtcResetSrcEnable),
		.oscPowerEnable(oscPowerEnable), .oscModeSelect(oscModeSelect),
		.gainControlEnable(gainControlEnable), .biasDouble(biasDouble),
		.slowClkRouted(slowClkRouted), .timerCaptureTick(timerCaptureTick),
		.rtcIrq(rtcIrq), .mcuResetReq(mcuResetReq), .wakeInternalOsc(wakeInternalOsc));

	// Clock generator
	always #5 sys_clk = ~sys_clk;

	// Pulse counters; pulses stand one cycle so each edge is looked at
	always @(posedge sys_clk)
	begin
		if (timerCaptureTick === 1'b1)
			ticks++;
		if (wakeInternalOsc === 1'b1)
			wakes++;
	end

	// Single comparison point
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		nCompared++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Verdict and end of run
	task automatic wrapUp();
		$display("compared %0d mismatches %0d", nCompared, nErrors);
		if (nErrors == 0 && nCompared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Load the indirect address; taken at the edge that lowers the strobe
	task automatic set_addr(input logic [7:0] a);
		@(posedge sys_clk);
		addrWrEn <= 1'b1;
		addrIn <= a;
		@(posedge sys_clk);
		addrWrEn <= 1'b0;
	endtask

	// Address first, data a cycle later, so the write never sees the old address
	task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
		set_addr(a);
		dataWrEn <= 1'b1;
		dataIn <= d;
		@(posedge sys_clk);
		dataWrEn <= 1'b0;
	endtask

	// Readback is one edge behind the address; two spare edges for margin
	task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
		set_addr(a);
		repeat (3) @(posedge sys_clk);
		#1;
		d = dataOut;
	endtask

	// Bounded poll for a self-clearing control bit
	task automatic wait_clear(input int b);
		logic [7:0] v;
		for (int i = 0; i < 10; i++)
		begin
			read_reg(8'h06, v);
			if (v[b] === 1'b0)
				return;
		end
		nErrors++;
		$display("mismatch poll of control bit expected 0 seen 1");
		wrapUp();
	endtask

	// Slow clock cycles, each level held well inside the detector window
	task automatic pulse_slow(input int n);
		repeat (n)
		begin
			@(posedge sys_clk);
			slowClkPin <= 1'b1;
			repeat (6) @(posedge sys_clk);
			slowClkPin <= 1'b0;
			repeat (6) @(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
	endtask

	initial
	begin
		repeat (5) @(posedge sys_clk);
		srst <= 1'b0;
		@(posedge sys_clk);
		#1;
		// Reset state
		check("power enable", oscPowerEnable, 8'h00);
		read_reg(8'h06, rd);
		check("control reset", rd, 8'h00);
		read_reg(8'h07, rd);
		check("osc reset", rd, 8'h00);
		read_reg(8'h00, rd);
		check("snapshot reset", rd, 8'hff);
		read_reg(8'h0d, rd);
		check("alarm reset", rd, 8'hff);
		write_reg(8'h0e, 8'h5a);
		read_reg(8'h0e, rd);
		check("unmapped", rd, 8'h00);
		$display("test reset done");
		// Oscillator control fields and clock valid readback
		write_reg(8'h07, 8'he0);
		read_reg(8'h07, rd);
		check("osc readback", rd, 8'he0);
		check("gain out", gainControlEnable, 8'h01);
		check("mode out", oscModeSelect, 8'h01);
		check("bias out", biasDouble, 8'h01);
		clockValidPin <= 1'b1;
		write_reg(8'h06, 8'h80);
		// Output launches on the write edge; look once it has settled
		#1;
		check("power out", oscPowerEnable, 8'h01);
		read_reg(8'h07, rd);
		check("clock valid", rd, 8'hf0);
		write_reg(8'h07, 8'h00);
		read_reg(8'h07, rd);
		check("valid read only", rd, 8'h10);
		check("self osc mode", oscModeSelect, 8'h00);
		check("self osc bias", biasDouble, 8'h00);
		$display("test oscillator done");
		// Load timer with one, run four slow cycles, snapshot
		for (int i = 0; i < 6; i++)
			write_reg(8'(i), (i == 0) ? 8'h02 : 8'h00);
		write_reg(8'h06, 8'h02);
		wait_clear(1);
		write_reg(8'h06, 8'h10);
		ticks = 0;
		pulse_slow(4);
		check("tick count", 8'(ticks), 8'h04);
		write_reg(8'h06, 8'h00);
		pulse_slow(2);
		write_reg(8'h06, 8'h01);
		wait_clear(0);
		read_reg(8'h00, rd);
		check("snapshot low", rd, 8'h0a);
		read_reg(8'h01, rd);
		check("snapshot next", rd, 8'h00);
		$display("test timer done");
		// Alarm at six: not yet at five, fires at equality, sticky
		for (int i = 0; i < 6; i++)
			write_reg(8'(8 + i), (i == 0) ? 8'h0c : 8'h00);
		write_reg(8'h06, 8'h08);
		read_reg(8'h06, rd);
		check("below alarm", rd, 8'h08);
		write_reg(8'h06, 8'h18);
		pulse_slow(1);
		read_reg(8'h06, rd);
		check("alarm set", rd, 8'h1c);
		check("irq", rtcIrq, 8'h01);
		check("wake alarm", 8'(wakes), 8'h01);
		write_reg(8'h06, 8'h04);
		read_reg(8'h06, rd);
		check("alarm sticky", rd, 8'h04);
		write_reg(8'h06, 8'h00);
		read_reg(8'h06, rd);
		check("alarm cleared", rd, 8'h00);
		check("irq cleared", rtcIrq, 8'h00);
		$display("test alarm done");
		// Detector: slow clock held still past the window
		write_reg(8'h06, 8'h40);
		// Both core enables off: the flag sets but neither path fires
		rtcIrqEnable <= 1'b0;
		rtcResetSrcEnable <= 1'b0;
		repeat (40) @(posedge sys_clk);
		read_reg(8'h06, rd);
		check("fail set", rd, 8'h60);
		check("reset masked", mcuResetReq, 8'h00);
		check("irq masked", rtcIrq, 8'h00);
		check("wake fail", 8'(wakes), 8'h02);
		rtcIrqEnable <= 1'b1;
		rtcResetSrcEnable <= 1'b1;
		repeat (40) @(posedge sys_clk);
		read_reg(8'h06, rd);
		check("fail sticky", rd, 8'h60);
		check("reset request", mcuResetReq, 8'h01);
		check("irq fail", rtcIrq, 8'h01);
		write_reg(8'h06, 8'h00);
		read_reg(8'h06, rd);
		check("fail cleared", rd, 8'h00);
		check("routed idle", slowClkRouted, 8'h00);
		// Pin to routed output is two sync flops plus the output flop
		slowClkPin <= 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		check("routed high", slowClkRouted, 8'h01);
		$display("test detector done");
		wrapUp();
	end
endmodule

`default_nettype wire
